// >>> hdl/lrbt_regs.vh
// Register map, field layout and reset values of the refresh and blink timing block.
// Included by the lrbt_timing module only; definitions only.
`ifndef LRBT_REGS_VH
`define LRBT_REGS_VH

`define LRBT_ADDR_BLINK_MASK   8'h9E
`define LRBT_ADDR_TOGGLE_DIV   8'h9F
`define LRBT_ADDR_PRESC_LOW    8'hA9
`define LRBT_ADDR_PRESC_HIGH   8'hAA

`define LRBT_RST_BYTE          8'h00
`define LRBT_ZERO_BYTE         8'h00
`define LRBT_PRESC_HI_W        2
`define LRBT_TOGGLE_CODE_W     4
`define LRBT_PRESC_HI_PAD      6'h00
`define LRBT_TOGGLE_PAD        4'h0

// Toggle divider codes
`define LRBT_TOGGLE_CODE_MIN   4'h2
`define LRBT_TOGGLE_CODE_MAX   4'hC
`define LRBT_TOGGLE_CODE_STEP  4'h1

// Blinkable segment masks per mux mode, two segments per common line
`define LRBT_SEG_LIM_STATIC    8'h03
`define LRBT_SEG_LIM_2         8'h0F
`define LRBT_SEG_LIM_3         8'h3F
`define LRBT_SEG_LIM_4         8'hFF

// Lcd clock divider: one rtc edge per step, shifted by the select
`define LRBT_LCD_DIV_ONE       3'h1

// Multiplex mode encodings
`define LRBT_MUX_STATIC        2'h0
`define LRBT_MUX_2             2'h1
`define LRBT_MUX_3             2'h2
`define LRBT_MUX_4             2'h3

`endif

// >>> hdl/lrbt_ticker.v
// Programmable period counter: pulses once every (limit+1) enable cycles.
// Assumes en is a one-cycle strobe on clk; limit may change at any time.
`timescale 1ns/1ps

module lrbt_ticker #(
    parameter W = 11
) (
    input  wire         clk,
    input  wire         nrst,
    input  wire         en,
    input  wire [W-1:0] limit,
    output reg          pulse_r
);
    reg [W-1:0] cnt_r;

    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r   <= {W{1'b0}};
            pulse_r <= 1'b0;
        end else begin
            pulse_r <= 1'b0;
            if (en) begin
                // Compare with >= so a lowered limit never strands the count
                if (cnt_r >= limit) begin
                    cnt_r   <= {W{1'b0}};
                    pulse_r <= 1'b1;
                end else begin
                    cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
                end
            end
        end
    end
endmodule // lrbt_ticker

// >>> hdl/lrbt_timing.v
// LCD refresh and blink timing: prescaler, toggle divider, blink mask and SFR access.
// Assumes a byte-wide SFR port on clk, and the real-time clock arriving unsynchronised.
`timescale 1ns/1ps
`include "lrbt_regs.vh"

module lrbt_timing #(
    parameter DIV_W = 11
) (
    input  wire       clk,
    input  wire       nrst,
    input  wire [7:0] sfr_addr,
    input  wire       sfr_wr,
    input  wire [7:0] sfr_wdata,
    input  wire       sfr_rd,
    output reg  [7:0] sfr_rdata_r,
    input  wire       rtc_clk,
    input  wire [1:0] lcd_clk_div_sel,
    input  wire [1:0] mux_mode,
    input  wire [7:0] first_segment_data_reg,
    output reg  [7:0] seg_data_out_r,
    output reg  [7:0] blink_active_r,
    output reg        blink_phase_r,
    output reg        refresh_tick_r,
    output reg        lcd_clk_tick_r
);
    reg  [7:0]                     blink_segment_mask_r;
    reg  [`LRBT_TOGGLE_CODE_W-1:0] toggle_divider_code_r;
    reg  [7:0]                     refresh_prescaler_low_r;
    reg  [`LRBT_PRESC_HI_W-1:0]    refresh_prescaler_high_r;
    reg                            rtc_meta_r;
    reg                            rtc_sync_r;
    reg                            rtc_prev_r;
    wire [9:0]                     refresh_divisor_value;
    wire                           rtc_rise;
    wire                           lcd_tick;
    wire                           phase_tick;
    wire                           refresh_tick;
    wire                           toggle_tick;
    reg  [7:0]                     rd_nxt;
    wire [2:0]                     lcd_div_limit;
    wire [DIV_W-1:0]               phase_limit;
    wire [2:0]                     refresh_limit;
    wire [DIV_W-1:0]               toggle_limit_w;

    // Divisor minus one for a toggle code; reserved codes are clamped to the nearest legal one
    function [DIV_W-1:0] toggle_limit;
        input [`LRBT_TOGGLE_CODE_W-1:0] code;
        reg   [`LRBT_TOGGLE_CODE_W-1:0] c;
        reg   [DIV_W:0]                 span;
        begin
            c = code;
            if (c < `LRBT_TOGGLE_CODE_MIN)
                c = `LRBT_TOGGLE_CODE_MIN;
            if (c > `LRBT_TOGGLE_CODE_MAX)
                c = `LRBT_TOGGLE_CODE_MAX;
            // Code n divides by 2^(n-1); the spare top bit keeps 2048 from wrapping
            span = {{DIV_W{1'b0}}, 1'b1} << (c - `LRBT_TOGGLE_CODE_STEP);
            span = span - {{DIV_W{1'b0}}, 1'b1};
            toggle_limit = span[DIV_W-1:0];
        end
    endfunction

    // Mask of segments that may blink for a mux mode: two per common line
    function [7:0] mux_seg_limit;
        input [1:0] mode;
        begin
            case (mode)
                `LRBT_MUX_STATIC: mux_seg_limit = `LRBT_SEG_LIM_STATIC;
                `LRBT_MUX_2:      mux_seg_limit = `LRBT_SEG_LIM_2;
                `LRBT_MUX_3:      mux_seg_limit = `LRBT_SEG_LIM_3;
                default:          mux_seg_limit = `LRBT_SEG_LIM_4;
            endcase
        end
    endfunction

    assign refresh_divisor_value = {refresh_prescaler_high_r, refresh_prescaler_low_r};

    // Counter limits; each ticker counts limit+1 enables per pulse
    assign lcd_div_limit  = (`LRBT_LCD_DIV_ONE << lcd_clk_div_sel) - `LRBT_LCD_DIV_ONE;
    assign phase_limit    = {refresh_divisor_value, 1'b1};
    assign refresh_limit  = {mux_mode, 1'b1};
    assign toggle_limit_w = toggle_limit(toggle_divider_code_r);

    // Register writes
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_segment_mask_r     <= `LRBT_RST_BYTE;
            toggle_divider_code_r    <= `LRBT_TOGGLE_PAD;
            refresh_prescaler_low_r  <= `LRBT_RST_BYTE;
            refresh_prescaler_high_r <= {`LRBT_PRESC_HI_W{1'b0}};
        end else if (sfr_wr) begin
            // Each prescaler byte takes effect alone; the phase divider sees a mixed value briefly
            case (sfr_addr)
                `LRBT_ADDR_BLINK_MASK: begin
                    blink_segment_mask_r <= sfr_wdata;
                end
                `LRBT_ADDR_TOGGLE_DIV: begin
                    toggle_divider_code_r <= sfr_wdata[`LRBT_TOGGLE_CODE_W-1:0];
                end
                `LRBT_ADDR_PRESC_LOW: begin
                    refresh_prescaler_low_r <= sfr_wdata;
                end
                `LRBT_ADDR_PRESC_HIGH: begin
                    refresh_prescaler_high_r <= sfr_wdata[`LRBT_PRESC_HI_W-1:0];
                end
                default: ;
            endcase
        end
    end

    // Register reads; unmapped addresses read zero
    always @* begin
        case (sfr_addr)
            `LRBT_ADDR_BLINK_MASK: rd_nxt = blink_segment_mask_r;
            `LRBT_ADDR_TOGGLE_DIV: rd_nxt = {`LRBT_TOGGLE_PAD, toggle_divider_code_r};
            `LRBT_ADDR_PRESC_LOW:  rd_nxt = refresh_prescaler_low_r;
            `LRBT_ADDR_PRESC_HIGH: rd_nxt = {`LRBT_PRESC_HI_PAD, refresh_prescaler_high_r};
            default:               rd_nxt = `LRBT_ZERO_BYTE;
        endcase
    end

    always @(posedge clk or negedge nrst) begin
        if (!nrst)
            sfr_rdata_r <= `LRBT_ZERO_BYTE;
        else if (sfr_rd)
            sfr_rdata_r <= rd_nxt;
    end

    // Real-time clock edges; the first stage feeds only the second
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            rtc_meta_r <= 1'b0;
            rtc_sync_r <= 1'b0;
            rtc_prev_r <= 1'b0;
        end else begin
            rtc_meta_r <= rtc_clk;
            rtc_sync_r <= rtc_meta_r;
            rtc_prev_r <= rtc_sync_r;
        end
    end
    assign rtc_rise = rtc_sync_r & ~rtc_prev_r;

    // Lcd clock: real-time clock divided by 1, 2, 4 or 8
    lrbt_ticker #(.W(3)) u_lcd_clk (
        .clk     (clk),
        .nrst    (nrst),
        .en      (rtc_rise),
        .limit   (lcd_div_limit),
        .pulse_r (lcd_tick)
    );

    // Phase tick every 2*(div+1) lcd clocks: refresh*mux*2 rate
    lrbt_ticker #(.W(DIV_W)) u_phase (
        .clk     (clk),
        .nrst    (nrst),
        .en      (lcd_tick),
        .limit   (phase_limit),
        .pulse_r (phase_tick)
    );

    // Refresh every 2*mux phase ticks, giving 4*mux*(div+1) lcd clocks
    lrbt_ticker #(.W(3)) u_refresh (
        .clk     (clk),
        .nrst    (nrst),
        .en      (phase_tick),
        .limit   (refresh_limit),
        .pulse_r (refresh_tick)
    );

    // Toggle event every divider phase ticks
    lrbt_ticker #(.W(DIV_W)) u_toggle (
        .clk     (clk),
        .nrst    (nrst),
        .en      (phase_tick),
        .limit   (toggle_limit_w),
        .pulse_r (toggle_tick)
    );

    // Blink phase and segment gating; runs with no software involvement
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            blink_phase_r  <= 1'b0;
            blink_active_r <= `LRBT_ZERO_BYTE;
            seg_data_out_r <= `LRBT_ZERO_BYTE;
        end else begin
            if (toggle_tick)
                blink_phase_r <= ~blink_phase_r;
            blink_active_r <= blink_segment_mask_r & mux_seg_limit(mux_mode);
            seg_data_out_r <= first_segment_data_reg &
                              ~(blink_active_r & {8{blink_phase_r}});
        end
    end

    // Tick outputs re-timed so the driver sees clean one-cycle pulses from flip-flops
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            refresh_tick_r <= 1'b0;
            lcd_clk_tick_r <= 1'b0;
        end else begin
            refresh_tick_r <= refresh_tick;
            lcd_clk_tick_r <= lcd_tick;
        end
    end
endmodule // lrbt_timing

// >>> sim/lrbt_assertions.sv
// Port-level checks of the refresh and blink timing block.
// Assumes it is bound to the top module, one clock domain.
`timescale 1ns/1ps
module lrbt_assertions (
    input wire       clk, nrst, sfr_wr, sfr_rd, rtc_clk,
    input wire [7:0] sfr_addr, sfr_wdata, sfr_rdata_r, first_segment_data_reg,
    input wire [7:0] seg_data_out_r, blink_active_r,
    input wire [1:0] lcd_clk_div_sel, mux_mode,
    input wire       blink_phase_r, refresh_tick_r, lcd_clk_tick_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_tog_pad;
        sfr_rd && sfr_addr == 8'h9F |=> sfr_rdata_r[7:4] == 4'h0;
    endproperty
    a_tog_pad: assert property (p_tog_pad) else $error("toggle pad not zero");
    property p_wr_rd(a, m);
        sfr_wr && !sfr_rd && sfr_addr == a ##1 sfr_rd && !sfr_wr && sfr_addr == a
            |=> sfr_rdata_r == ($past(sfr_wdata, 2) & m);
    endproperty
    a_hi_wr: assert property (p_wr_rd(8'hAA, 8'h03)) else $error("high byte");
    a_lo_wr: assert property (p_wr_rd(8'hA9, 8'hFF)) else $error("low byte");
    a_mask_wr: assert property (p_wr_rd(8'h9E, 8'hFF)) else $error("mask byte");
    property p_static_lim;
        $stable(mux_mode) && mux_mode == 2'h0 |-> blink_active_r[7:2] == 6'h00;
    endproperty
    a_static_lim: assert property (p_static_lim) else $error("blink limit");
    property p_seg_out;
        $past(nrst) |-> seg_data_out_r == ($past(first_segment_data_reg)
            & ~($past(blink_active_r) & {8{$past(blink_phase_r)}}));
    endproperty
    a_seg_out: assert property (p_seg_out) else $error("segment out");
    property p_ref_gap;
        refresh_tick_r |=> !refresh_tick_r [*6];
    endproperty
    a_ref_gap: assert property (p_ref_gap) else $error("refresh gap");
    property p_lcd_pulse;
        lcd_clk_tick_r |=> !lcd_clk_tick_r;
    endproperty
    a_lcd_pulse: assert property (p_lcd_pulse) else $error("lcd tick");
    c_flip: cover property ($rose(blink_phase_r));
    c_ref: cover property (refresh_tick_r);
    c_blank: cover property (blink_phase_r && blink_active_r != 8'h00);
endmodule // lrbt_assertions

// >>> sim/lrbt_drv_model.sv
// Waveform driver stand-in: measures tick spacing as the driver sees it.
// Assumes one-cycle tick pulses on clk.
`timescale 1ns/1ps
module lrbt_drv_model (
    input wire clk, nrst, lcd_tick, refresh_tick, phase,
    output int ref_span, flip_span, clk_span
);
    int nl, nf, nc;
    logic ph_q;
    always @(posedge clk or negedge nrst)
        if (!nrst) begin
            {nl, nf, nc, ph_q} = '0;
        end else begin
            nc++;
            if (lcd_tick) begin
                clk_span = nc; nc = 0; nl++; nf++;
            end
            if (refresh_tick) begin
                ref_span = nl; nl = 0;
            end
            if (phase != ph_q) begin
                flip_span = nf; nf = 0;
            end
            ph_q = phase;
        end
endmodule // lrbt_drv_model

// >>> sim/tb_lcd_refresh_and_blink_timing.sv
// Bench: registers, lcd clock, refresh rate and blinking of the timing block.
// Assumes the driver model and a free-running real-time clock of 80 ns.
`timescale 1ns/1ps
module tb_lcd_refresh_and_blink_timing;
    logic clk = 0, nrst = 0, rtc = 0, wr = 0, rd = 0;
    logic [7:0] addr = 8'h00, wd = 8'h00, seg = 8'hFF;
    logic [1:0] sel = 2'h0, mux = 2'h0;
    wire [7:0] rdat, sout, act;
    wire ph, rtk, ltk;
    int ref_span, flip_span, clk_span, n_fail = 0, check_count = 0;
    always #4 clk = ~clk;
    initial #3 forever #40 rtc = ~rtc;
    lrbt_timing dut (.clk(clk), .nrst(nrst), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wd),
        .sfr_rd(rd), .sfr_rdata_r(rdat), .rtc_clk(rtc), .lcd_clk_div_sel(sel),
        .mux_mode(mux), .first_segment_data_reg(seg), .seg_data_out_r(sout),
        .blink_active_r(act), .blink_phase_r(ph), .refresh_tick_r(rtk), .lcd_clk_tick_r(ltk));
    lrbt_drv_model model (.clk(clk), .nrst(nrst), .lcd_tick(ltk), .refresh_tick(rtk),
        .phase(ph), .ref_span(ref_span), .flip_span(flip_span), .clk_span(clk_span));
    task automatic chk(input logic [15:0] got, exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, d);
        @(negedge clk); addr = a; wd = d; wr = 1;
        @(negedge clk); wr = 0;
    endtask
    task automatic rd_reg(input logic [7:0] a, e);
        @(negedge clk); addr = a; rd = 1;
        @(negedge clk); rd = 0; chk(rdat, e);
    endtask
    task automatic wr_rd(input logic [7:0] a, d, e);
        wr_reg(a, d); addr = a; rd = 1;
        @(negedge clk); rd = 0; chk(rdat, e);
    endtask
    task automatic settle();
        repeat (2) @(negedge clk);
    endtask
    task automatic t_regs();
        logic [7:0] am[5] = '{8'h9E, 8'h9F, 8'hA9, 8'hAA, 8'hA0};
        logic [7:0] em[5] = '{8'hF2, 8'h02, 8'hF2, 8'h02, 8'h00};
        foreach (am[i]) rd_reg(am[i], 8'h00);
        foreach (am[i]) wr_rd(am[i], 8'hF2, em[i]);
    endtask
    task automatic t_lcdclk();
        sel = 2'h1; repeat (3) @(posedge ltk); settle(); chk(clk_span, 20);
        sel = 2'h3; repeat (3) @(posedge ltk); settle(); chk(clk_span, 80);
        sel = 2'h0;
    endtask
    task automatic t_refresh();
        wr_reg(8'hA9, 8'h02); wr_reg(8'hAA, 8'h00);
        for (int m = 0; m < 4; m++) begin
            mux = m[1:0]; repeat (2) @(posedge rtk); settle();
            chk(ref_span, 12 * (m + 1));
        end
        mux = 2'h0; wr_reg(8'hA9, 8'h00); wr_reg(8'hAA, 8'h01);
        repeat (2) @(posedge rtk); settle(); chk(ref_span, 1028);
        wr_reg(8'hAA, 8'h00);
    endtask
    task automatic t_blink();
        wr_reg(8'h9F, 8'h02); wr_reg(8'h9E, 8'h85);
        repeat (3) @(ph); settle(); chk(flip_span, 4);
        wr_reg(8'h9F, 8'h04);
        repeat (3) @(ph); settle(); chk(flip_span, 16);
        chk(act, 8'h01);
        wait (ph === 1'b1); settle(); chk(sout, 8'hFE);
        wait (ph === 1'b0); settle(); chk(sout, 8'hFF);
        mux = 2'h3; settle(); chk(act, 8'h85);
    endtask
    task automatic complete_run();
        $display("checks=%0d failures=%0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        @(negedge clk); nrst = 1;
        t_regs(); t_lcdclk(); t_refresh(); t_blink();
        complete_run();
    end
    initial begin
        repeat (60000) @(posedge clk);
        n_fail++;
        complete_run();
    end
endmodule // tb_lcd_refresh_and_blink_timing
bind lrbt_timing lrbt_assertions chk_i (.clk(clk), .nrst(nrst), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .rtc_clk(rtc_clk), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_rdata_r(sfr_rdata_r), .first_segment_data_reg(first_segment_data_reg),
    .seg_data_out_r(seg_data_out_r), .blink_active_r(blink_active_r),
    .lcd_clk_div_sel(lcd_clk_div_sel), .mux_mode(mux_mode), .blink_phase_r(blink_phase_r),
    .refresh_tick_r(refresh_tick_r), .lcd_clk_tick_r(lcd_clk_tick_r));
